// *** rtl/dsg_pkg.sv ***
/*
  Constants for the deep-sleep clock gating and software reset block:
  register offsets, field positions, writable masks and reset values.
  Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
package dsg_pkg;

  localparam int          ADR_W = 12;
  localparam int          DAT_W = 32;
  localparam int          NPER  = 9;

  // Register byte offsets
  localparam logic [11:0] OFF_SOFT_RST   = 12'h040;
  localparam logic [11:0] OFF_DS_GATE    = 12'h128;
  localparam logic [11:0] OFF_RUN_GATE   = 12'h200;
  localparam logic [11:0] OFF_SLP_GATE   = 12'h204;
  localparam logic [11:0] OFF_RUN_CFG    = 12'h208;
  localparam logic [11:0] OFF_IRQ_STAT   = 12'h20c;
  localparam logic [11:0] OFF_IRQ_CLR    = 12'h210;
  localparam logic [11:0] OFF_IRQ_EN     = 12'h214;

  // Gating register fields
  localparam int          BIT_ETH_PHY    = 30;
  localparam int          BIT_ETH_MAC    = 28;
  localparam int          BIT_PORT_A     = 0;
  localparam int          NPORTS         = 7;
  localparam logic [31:0] GATE_WR_MASK   = 32'h5000_007f;

  // Software reset fields
  localparam int          BIT_PWM_RST    = 20;
  localparam int          BIT_WDOG_RST   = 3;
  localparam logic [31:0] SRST_WR_MASK   = 32'h0010_0008;

  // Run clock configuration fields
  localparam int          BIT_AUTO_GATE  = 0;
  localparam logic [31:0] RCFG_WR_MASK   = 32'h0000_0001;

  // Fault status layout: bit i is peripheral i of the gate vector
  localparam logic [31:0] IRQ_MASK       = 32'h0000_01ff;

  localparam logic [31:0] RST_ZERO       = 32'h0000_0000;
  localparam logic [8:0]  PER_ZERO       = 9'h000;

  typedef enum logic [1:0] {
    DSG_RUN,
    DSG_SLEEP,
    DSG_DEEP
  } dsg_mode_t;

endpackage

// *** rtl/dsg_top.sv ***
/*
  Deep-sleep clock gating and software reset registers with a Wishbone
  slave, per-peripheral clock enables, software reset outputs and a bus
  fault detector for accesses to gated peripherals.
  Assumes one clock, a synchronous active-high reset, a power-mode state
  supplied by the system, and the capability word as a static input.
*/
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module dsg_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [11:0] adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        sleep_i,
  input  wire logic        deep_sleep_i,
  input  wire logic [31:0] cap_word_one_i,
  input  wire logic [8:0]  periph_req_i,
  output logic             eth_phy_gate_o,
  output logic             eth_mac_gate_o,
  output logic             port_a_gate_o,
  output logic             port_b_gate_o,
  output logic             port_c_gate_o,
  output logic             port_d_gate_o,
  output logic             port_e_gate_o,
  output logic             port_f_gate_o,
  output logic             port_g_gate_o,
  output logic             pwm_reset_o,
  output logic             watchdog_reset_ctrl_o,
  output logic             bus_fault_o,
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [31:0] soft_reset_ctrl_zero;
    logic [31:0] deep_sleep_clock_gate_two;
    logic [31:0] run_clock_gate_two;
    logic [31:0] sleep_clock_gate_two;
    logic [31:0] run_clock_config;
    logic [8:0]  irq_stat;
    logic [8:0]  irq_en;
    logic [8:0]  gate;
    logic [31:0] rdata;
    logic        ack;
    logic        fault;
    logic        irq;
    logic        pwm_rst;
    logic        wdog_rst;
  } dsg_state_t;

  dsg_state_t st_r;
  dsg_state_t st_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte-lane merge limited to the writable bits of a register
  function automatic logic [31:0] dsg_merge(input logic [31:0] old,
                                            input logic [31:0] wdat,
                                            input logic [3:0]  sel,
                                            input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & wmask;
    return (old & ~m) | (wdat & m);
  endfunction

  // Gate register to peripheral vector: {ports G..A, MAC, PHY} order
  function automatic logic [8:0] dsg_per(input logic [31:0] g);
    return {g[dsg_pkg::BIT_PORT_A +: dsg_pkg::NPORTS],
            g[dsg_pkg::BIT_ETH_MAC], g[dsg_pkg::BIT_ETH_PHY]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Mode selection

  dsg_pkg::dsg_mode_t mode;
  logic [31:0]        eff_gate;

  always_comb begin
    // Sleep states count only when automatic gating is selected
    if (st_r.run_clock_config[dsg_pkg::BIT_AUTO_GATE] && deep_sleep_i) begin
      mode = dsg_pkg::DSG_DEEP;
    end else if (st_r.run_clock_config[dsg_pkg::BIT_AUTO_GATE] && sleep_i) begin
      mode = dsg_pkg::DSG_SLEEP;
    end else begin
      mode = dsg_pkg::DSG_RUN;
    end
    case (mode)
      dsg_pkg::DSG_DEEP:  eff_gate = st_r.deep_sleep_clock_gate_two;
      dsg_pkg::DSG_SLEEP: eff_gate = st_r.sleep_clock_gate_two;
      dsg_pkg::DSG_RUN:   eff_gate = st_r.run_clock_gate_two;
      default:            eff_gate = dsg_pkg::RST_ZERO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  logic        req;
  logic        wr;
  logic [8:0]  fault_vec;
  logic [8:0]  clr_vec;

  always_comb begin
    st_nxt    = st_r;
    req       = cyc_i && stb_i && !st_r.ack;
    wr        = req && we_i;
    clr_vec   = dsg_pkg::PER_ZERO;
    // Uses the registered enables, matching what the peripherals see
    fault_vec = periph_req_i & ~st_r.gate;

    // Ack for one cycle, then drop even if the master lingers
    st_nxt.ack   = req;
    st_nxt.rdata = dsg_pkg::RST_ZERO;

    if (wr) begin
      case (adr_i)
        dsg_pkg::OFF_SOFT_RST: begin
          // Bits for absent peripherals never become writable
          st_nxt.soft_reset_ctrl_zero = dsg_merge(st_r.soft_reset_ctrl_zero, dat_i, sel_i,
            dsg_pkg::SRST_WR_MASK & cap_word_one_i);
        end
        dsg_pkg::OFF_DS_GATE: begin
          st_nxt.deep_sleep_clock_gate_two = dsg_merge(st_r.deep_sleep_clock_gate_two,
            dat_i, sel_i, dsg_pkg::GATE_WR_MASK);
        end
        dsg_pkg::OFF_RUN_GATE: begin
          st_nxt.run_clock_gate_two = dsg_merge(st_r.run_clock_gate_two,
            dat_i, sel_i, dsg_pkg::GATE_WR_MASK);
        end
        dsg_pkg::OFF_SLP_GATE: begin
          st_nxt.sleep_clock_gate_two = dsg_merge(st_r.sleep_clock_gate_two,
            dat_i, sel_i, dsg_pkg::GATE_WR_MASK);
        end
        dsg_pkg::OFF_RUN_CFG: begin
          st_nxt.run_clock_config = dsg_merge(st_r.run_clock_config,
            dat_i, sel_i, dsg_pkg::RCFG_WR_MASK);
        end
        dsg_pkg::OFF_IRQ_CLR: begin
          clr_vec = 9'(dsg_merge(dsg_pkg::RST_ZERO, dat_i, sel_i, dsg_pkg::IRQ_MASK));
        end
        dsg_pkg::OFF_IRQ_EN: begin
          st_nxt.irq_en = 9'(dsg_merge({23'h000000, st_r.irq_en}, dat_i, sel_i,
            dsg_pkg::IRQ_MASK));
        end
        default: begin
          // Unmapped or read-only: acknowledged, no effect
        end
      endcase
    end else if (req) begin
      case (adr_i)
        dsg_pkg::OFF_SOFT_RST: st_nxt.rdata = st_r.soft_reset_ctrl_zero;
        dsg_pkg::OFF_DS_GATE:  st_nxt.rdata = st_r.deep_sleep_clock_gate_two;
        dsg_pkg::OFF_RUN_GATE: st_nxt.rdata = st_r.run_clock_gate_two;
        dsg_pkg::OFF_SLP_GATE: st_nxt.rdata = st_r.sleep_clock_gate_two;
        dsg_pkg::OFF_RUN_CFG:  st_nxt.rdata = st_r.run_clock_config;
        dsg_pkg::OFF_IRQ_STAT: st_nxt.rdata = {23'h000000, st_r.irq_stat};
        dsg_pkg::OFF_IRQ_EN:   st_nxt.rdata = {23'h000000, st_r.irq_en};
        default:               st_nxt.rdata = dsg_pkg::RST_ZERO;
      endcase
    end

    // A fault in the clearing cycle stays recorded
    st_nxt.irq_stat = (st_r.irq_stat & ~clr_vec) | fault_vec;
    st_nxt.fault    = |fault_vec;
    st_nxt.irq      = |(st_r.irq_stat & st_r.irq_en);

    st_nxt.gate     = dsg_per(eff_gate);
    st_nxt.pwm_rst  = st_r.soft_reset_ctrl_zero[dsg_pkg::BIT_PWM_RST];
    st_nxt.wdog_rst = st_r.soft_reset_ctrl_zero[dsg_pkg::BIT_WDOG_RST];

    if (rst_i) begin
      st_nxt = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_i) begin
    st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign dat_o                 = st_r.rdata;
  assign ack_o                 = st_r.ack;
  assign eth_phy_gate_o        = st_r.gate[0];
  assign eth_mac_gate_o        = st_r.gate[1];
  assign port_a_gate_o         = st_r.gate[2];
  assign port_b_gate_o         = st_r.gate[3];
  assign port_c_gate_o         = st_r.gate[4];
  assign port_d_gate_o         = st_r.gate[5];
  assign port_e_gate_o         = st_r.gate[6];
  assign port_f_gate_o         = st_r.gate[7];
  assign port_g_gate_o         = st_r.gate[8];
  assign pwm_reset_o           = st_r.pwm_rst;
  assign watchdog_reset_ctrl_o = st_r.wdog_rst;
  assign bus_fault_o           = st_r.fault;
  assign irq_o                 = st_r.irq;

endmodule

`default_nettype wire

// *** sim/dsg_checker_assertions.sv ***
/* Port assertions for dsg_top.
   Assumes the bind below and a single clock domain. */
`timescale 1ns/1ps
`default_nettype none
module dsg_checker (
  input wire logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
  input wire logic        eth_phy_gate_o, eth_mac_gate_o, port_a_gate_o, port_b_gate_o,
  input wire logic        port_c_gate_o, port_d_gate_o, port_e_gate_o, port_f_gate_o,
  input wire logic        port_g_gate_o, pwm_reset_o, watchdog_reset_ctrl_o, bus_fault_o,
  input wire logic [11:0] adr_i,
  input wire logic [31:0] dat_i, dat_o, cap_word_one_i,
  input wire logic [3:0]  sel_i,
  input wire logic [8:0]  periph_req_i
);
  wire logic [8:0] gv = {port_g_gate_o, port_f_gate_o, port_e_gate_o, port_d_gate_o,
    port_c_gate_o, port_b_gate_o, port_a_gate_o, eth_mac_gate_o, eth_phy_gate_o};
  wire logic srw = cyc_i && stb_i && we_i && !ack_o && adr_i == dsg_pkg::OFF_SOFT_RST;
  wire logic bad = |(periph_req_i & ~gv);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // Own override: reset itself is the cause here
  property p_rst_zero;
    disable iff (1'b0) rst_i |=> gv == 9'h000 && !pwm_reset_o && !watchdog_reset_ctrl_o;
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("outputs not zero after reset");
  property p_fault; bad |=> bus_fault_o; endproperty
  a_fault: assert property (p_fault) else $error("gated access without fault");
  property p_no_fault; !bad |=> !bus_fault_o; endproperty
  a_no_fault: assert property (p_no_fault) else $error("fault without gated access");
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack not a one-cycle answer");
  property p_idle_rd; !ack_o |-> dat_o == 32'h0; endproperty
  a_idle_rd: assert property (p_idle_rd) else $error("read data outside ack");
  property p_gate_rsv;
    ack_o && !we_i && adr_i == dsg_pkg::OFF_DS_GATE |-> (dat_o & ~dsg_pkg::GATE_WR_MASK) == 0;
  endproperty
  a_gate_rsv: assert property (p_gate_rsv) else $error("gate reserved bit set");
  property p_srst_rsv;
    ack_o && !we_i && adr_i == dsg_pkg::OFF_SOFT_RST |-> (dat_o & ~dsg_pkg::SRST_WR_MASK) == 0;
  endproperty
  a_srst_rsv: assert property (p_srst_rsv) else $error("reset reserved bit set");
  property p_srst_mask; srw && !cap_word_one_i[20] && !pwm_reset_o |=> !pwm_reset_o [*2]; endproperty
  a_srst_mask: assert property (p_srst_mask) else $error("masked reset bit set");
  property p_pwm_set; srw && cap_word_one_i[20] && dat_i[20] && sel_i[2] |=> ##1 pwm_reset_o;
  endproperty
  a_pwm_set: assert property (p_pwm_set) else $error("pwm reset not set");
  c_fault: cover property (bus_fault_o);
  c_pwm: cover property (pwm_reset_o && watchdog_reset_ctrl_o);
  c_all_on: cover property (gv == 9'h1ff);
endmodule
bind dsg_top dsg_checker i_dsg_checker (.*);
`default_nettype wire

// *** sim/tb.sv ***
/* Self-checking bench for dsg_top.
   Waits for ack rather than assuming the one-cycle Wishbone answer of the design notes. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
  logic        sleep_i = 1'h0, deep_sleep_i = 1'h0, ack_o, pwm_reset_o, watchdog_reset_ctrl_o;
  logic        eth_phy_gate_o, eth_mac_gate_o, port_a_gate_o, port_b_gate_o, port_c_gate_o;
  logic        port_d_gate_o, port_e_gate_o, port_f_gate_o, port_g_gate_o, bus_fault_o, irq_o;
  logic [11:0] adr_i = '0;
  logic [31:0] dat_i = '0, cap_word_one_i = '0, dat_o, d;
  logic [3:0]  sel_i = 4'hf;
  logic [8:0]  periph_req_i = '0, gv, r;
  logic [31:0] q[$];
  int          num_errors = 0, checked = 0, seed = 32'hb889b30b, n;
  always #50 clk_i = ~clk_i;
  assign gv = {port_g_gate_o, port_f_gate_o, port_e_gate_o, port_d_gate_o, port_c_gate_o,
    port_b_gate_o, port_a_gate_o, eth_mac_gate_o, eth_phy_gate_o};
  dsg_top i_dsg_top (.*);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    // A read whose answer never came is a mismatch too
    if (q.size() != 0) num_errors++;
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge clk_i);
  endtask
  // Master never assumes the one-cycle answer
  task automatic wb(logic w, logic [11:0] a, logic [31:0] v);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, v};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'h1 && n < 20);
    if (ack_o !== 1'h1) begin
      num_errors++;
      end_of_test();
    end
    {cyc_i, stb_i} <= 2'h0;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e);
    q.push_back(e);
    wb(1'h0, a, '0);
  endtask
  task automatic irq_step(logic [11:0] a, logic [31:0] v, logic e);
    wb(1'h1, a, v);
    tick(2);
    chk("irq", irq_o, e);
  endtask
  task automatic strobe(logic [8:0] v);
    @(posedge clk_i);
    periph_req_i <= v;
    @(posedge clk_i);
    periph_req_i <= '0;
    @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    if (ack_o === 1'h1 && we_i === 1'h0 && q.size() > 0) begin
      chk("rdata", dat_o, q.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(3);
    rst_i <= 1'h0;
    chk("gates", gv, '0);
    rd(dsg_pkg::OFF_SOFT_RST, '0);
    wb(1'h1, dsg_pkg::OFF_IRQ_EN, 32'h1ff);
    strobe(9'h004);
    chk("fault", bus_fault_o, 1'h1);
    tick(1);
    chk("irq", irq_o, 1'h1);
    rd(dsg_pkg::OFF_IRQ_STAT, 32'h4);
    irq_step(dsg_pkg::OFF_IRQ_EN, '0, 1'h0);
    irq_step(dsg_pkg::OFF_IRQ_EN, 32'h1ff, 1'h1);
    irq_step(dsg_pkg::OFF_IRQ_CLR, 32'h1ff, 1'h0);
    wb(1'h1, dsg_pkg::OFF_RUN_CFG, 32'h1);
    deep_sleep_i <= 1'h1;
    for (int i = 0; i < 5; i++) begin
      d = (i == 0) ? '1 : $random(seed);
      r = $random(seed);
      wb(1'h1, dsg_pkg::OFF_DS_GATE, d);
      rd(dsg_pkg::OFF_DS_GATE, d & dsg_pkg::GATE_WR_MASK);
      chk("gates", gv, {d[6:0], d[28], d[30]});
      strobe(r);
      chk("fault", bus_fault_o, |(r & ~{d[6:0], d[28], d[30]}));
    end
    wb(1'h1, dsg_pkg::OFF_DS_GATE, '0);
    sel_i <= 4'h8;
    wb(1'h1, dsg_pkg::OFF_DS_GATE, '1);
    sel_i <= 4'hf;
    rd(dsg_pkg::OFF_DS_GATE, 32'h5000_0000);
    deep_sleep_i <= 1'h0;
    wb(1'h1, dsg_pkg::OFF_SLP_GATE, 32'h55);
    sleep_i <= 1'h1;
    tick(3);
    chk("gates", gv, 9'h154);
    wb(1'h1, dsg_pkg::OFF_RUN_CFG, '0);
    tick(3);
    chk("gates", gv, '0);
    wb(1'h1, 12'h3f0, '1);
    rd(12'h3f0, '0);
    for (int k = 0; k < 3; k++) begin
      d = (k == 0) ? ($random(seed) | 32'h0010_0008) : ((k == 1) ? 32'h0010_0000 : 32'h0000_0008);
      cap_word_one_i <= '1;
      wb(1'h1, dsg_pkg::OFF_SOFT_RST, '0);
      cap_word_one_i <= d;
      wb(1'h1, dsg_pkg::OFF_SOFT_RST, '1);
      rd(dsg_pkg::OFF_SOFT_RST, d & dsg_pkg::SRST_WR_MASK);
      chk("pwm", pwm_reset_o, d[20]);
      chk("wdog", watchdog_reset_ctrl_o, d[3]);
    end
    rst_i <= 1'h1;
    tick(2);
    rst_i <= 1'h0;
    rd(dsg_pkg::OFF_DS_GATE, '0);
    rd(dsg_pkg::OFF_SOFT_RST, '0);
    tick(2);
    end_of_test();
  end
endmodule
`default_nettype wire
